// >>> core/mpc_power_ctrl.sv
// power control and sleep-state controller of a processor module
// assumes power good and button come from the carrier board with pad
// pull-ups, so an undriven line reads high; sleep requests and wake
// events come from on-module logic in the same clock domain
`timescale 1ns/1ns
`include "mpc_regs.svh"

// Contract
// R1 - power good high starts onboard sequencing
// R2 - reset held while power good low
// R3 - carrier keeps power good low until stable
// R4 - carrier delays power good about 100ms
// R5 - carrier drives low, then floats line
// R6 - undriven power good still lets sequencing complete
// R7 - active-low supply on output requests main power
// R8 - debounced button press requests power on/off
// R9 - button response chosen by configuration input
// R10 - suspend to ram state supported
// R11 - deepest sleep entered only from S3/S4/S5
// R12 - entry conditions decide context preservation
// R13 - deepest sleep powers only the wake island
// R14 - wake returns to the entering sleep state
// R15 - inputs synchronised before use
module mpc_power_ctrl (
  input  wire logic       i_ref_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_power_good_in,
  input  wire logic       i_power_button_n,
  input  wire logic [1:0] i_button_action,
  input  wire logic       i_sleep_req,
  input  wire logic [1:0] i_sleep_type,
  input  wire logic       i_deep_enable,
  input  wire logic       i_wake_event,
  output logic            o_sys_rst_n,
  output logic            o_supply_on_n,
  output logic [2:0]      o_power_state,
  output logic            o_island_only,
  output logic            o_context_kept
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic [1:0] rst_sync;  // release shift register
  logic       rst_n;     // released reset used by the whole design

  // assert at once, release after two clock edges
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'h1};
    end
  end

  assign rst_n = rst_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // input conditioning

  logic pg_s;      // synchronised power good
  logic btn_s_n;   // synchronised button, low = pressed
  logic press;     // one-cycle button press

  // carrier levels pass two flops before any decision
  mpc_sync u_sync (                              // R15
    .i_ref_clk        (i_ref_clk),
    .i_rst_n          (rst_n),
    .i_power_good_in  (i_power_good_in),
    .i_power_button_n (i_power_button_n),
    .o_power_good     (pg_s),
    .o_button_n       (btn_s_n)
  );

  // the carrier debounces, so a falling edge is one request
  mpc_press u_press (                            // R8
    .i_ref_clk  (i_ref_clk),
    .i_rst_n    (rst_n),
    .i_button_n (btn_s_n),
    .o_press    (press)
  );

  ////////////////////////////////////////////////////////////////////////////
  // controller state

  localparam mpc_pkg::mpc_ctl_t CTL_RST = '{
    st:     mpc_pkg::st_s5,
    from:   mpc_pkg::st_s5,
    cnt:    8'h00,
    rst_n:  1'h0,
    son_n:  1'h1,
    island: 1'h0,
    ctx:    1'h0
  };
  localparam logic [7:0] SEQ_LAST  = 8'(`MPC_SEQ_CYC - 1);
  localparam logic [7:0] DEEP_LAST = 8'(`MPC_DEEP_CYC - 1);

  mpc_pkg::mpc_ctl_t   r;       // registered state
  mpc_pkg::mpc_ctl_t   next_r;  // next state
  mpc_pkg::mpc_action_t act;    // configured button response
  mpc_pkg::mpc_sleep_t  slp;    // requested sleep type
  logic                 wake;   // accepted wake event

  assign act  = mpc_pkg::mpc_action_t'(i_button_action);
  assign slp  = mpc_pkg::mpc_sleep_t'(i_sleep_type);
  assign wake = press | i_wake_event;

  // true for the three states that may drop into deepest sleep
  function automatic logic is_sleep(input mpc_pkg::mpc_state_t s);
    is_sleep = (s == mpc_pkg::st_s3) || (s == mpc_pkg::st_s4) ||
               (s == mpc_pkg::st_s5);
  endfunction : is_sleep

  // next state and outputs
  always_comb begin
    next_r = r;
    case (r.st)
      // sleep states: wake resumes, long dwell may go deeper
      mpc_pkg::st_s3, mpc_pkg::st_s4, mpc_pkg::st_s5: begin
        if (wake && !(r.st == mpc_pkg::st_s5 && press &&
                      act == mpc_pkg::act_off)) begin
          next_r.st  = mpc_pkg::st_pwrup;  // R8
          next_r.cnt = 8'h00;
        end else if (!i_deep_enable) begin
          next_r.cnt = 8'h00;
        end else if (r.cnt == DEEP_LAST) begin
          next_r.st   = mpc_pkg::st_deep;  // R11
          next_r.from = r.st;              // R14
          // only suspend to ram keeps memory alive
          next_r.ctx  = (r.st == mpc_pkg::st_s3);  // R12
          next_r.cnt  = 8'h00;
        end else begin
          next_r.cnt = r.cnt + 8'h01;
        end
      end
      // supply on; sequence starts once power good is seen
      mpc_pkg::st_pwrup: begin
        if (!pg_s) begin
          next_r.cnt = 8'h00;                // R2
        end else if (r.cnt == SEQ_LAST) begin
          next_r.st  = mpc_pkg::st_s0;       // R1 R6
          next_r.cnt = 8'h00;
        end else begin
          next_r.cnt = r.cnt + 8'h01;        // R1
        end
      end
      // running: loss of power good, button, software sleep
      mpc_pkg::st_s0: begin
        if (!pg_s) begin
          next_r.st = mpc_pkg::st_pwrup;     // R2
        end else if (press) begin
          case (act)                         // R9
            mpc_pkg::act_power: next_r.st = mpc_pkg::st_s5;
            mpc_pkg::act_off:   next_r.st = mpc_pkg::st_s5;
            mpc_pkg::act_sleep: next_r.st = mpc_pkg::st_s3;
            default:            next_r.st = r.st;
          endcase
        end else if (i_sleep_req) begin
          case (slp)
            mpc_pkg::slp_s3: next_r.st = mpc_pkg::st_s3;  // R10
            mpc_pkg::slp_s4: next_r.st = mpc_pkg::st_s4;
            mpc_pkg::slp_s5: next_r.st = mpc_pkg::st_s5;
            default:         next_r.st = r.st;
          endcase
        end
        next_r.cnt = 8'h00;
      end
      // deepest sleep: any press or wake event returns to entering state
      mpc_pkg::st_deep: begin
        if (wake) begin
          next_r.st  = r.from;               // R14
          next_r.cnt = 8'h00;
        end
      end
      default: begin
        next_r = CTL_RST;
      end
    endcase
    // outputs follow the next state so they leave flops directly
    next_r.rst_n  = (next_r.st == mpc_pkg::st_s0);                // R2
    next_r.son_n  = !((next_r.st == mpc_pkg::st_s0) ||
                      (next_r.st == mpc_pkg::st_pwrup));           // R7
    next_r.island = (next_r.st == mpc_pkg::st_deep);              // R13
    if (next_r.st != mpc_pkg::st_deep) begin
      next_r.ctx = 1'h0;
    end
  end

  // register the whole state
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= CTL_RST;
    end else begin
      r <= next_r;
    end
  end

  assign o_sys_rst_n    = r.rst_n;
  assign o_supply_on_n  = r.son_n;
  assign o_power_state  = r.st;
  assign o_island_only  = r.island;
  assign o_context_kept = r.ctx;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!rst_n);

  // deepest sleep entered from some state
  sequence s_enter_deep;
    r.st != mpc_pkg::st_deep ##1 r.st == mpc_pkg::st_deep;
  endsequence

  // running and a press under a given response
  sequence s_press_run(mpc_pkg::mpc_action_t a);
    r.st == mpc_pkg::st_s0 && pg_s && press && act == a;
  endsequence

  a_sync_delay: assert property (                              // R15
    $rose(pg_s) |-> $past(i_power_good_in, 2))
    else $error("power good used before two sync stages");

  a_rst_held: assert property (!pg_s |=> !o_sys_rst_n)         // R2
    else $error("reset released while power good low");

  a_seq_start: assert property (                               // R1
    $rose(o_sys_rst_n) |-> $past(pg_s) && $past(r.cnt) == SEQ_LAST)
    else $error("reset released without full sequencing");

  a_supply_up: assert property (                               // R7
    r.st == mpc_pkg::st_s5 && press && act == mpc_pkg::act_power
    |=> r.st == mpc_pkg::st_pwrup && !o_supply_on_n)
    else $error("supply not requested after power press");

  a_btn_off: assert property (                                 // R8
    s_press_run(mpc_pkg::act_power) |=> o_supply_on_n && !o_sys_rst_n)
    else $error("power press did not switch off");

  a_btn_ignore: assert property (                              // R9
    s_press_run(mpc_pkg::act_ignore) |=> r.st == mpc_pkg::st_s0)
    else $error("ignored press changed state");

  a_s3_entry: assert property (                                // R10
    r.st == mpc_pkg::st_s0 && pg_s && !press && i_sleep_req &&
    slp == mpc_pkg::slp_s3 |=> r.st == mpc_pkg::st_s3)
    else $error("suspend to ram not entered");

  a_deep_from: assert property (                               // R11
    s_enter_deep |-> is_sleep($past(r.st)) && r.from == $past(r.st))
    else $error("deepest sleep entered from wrong state");

  a_ctx_keep: assert property (                                // R12
    s_enter_deep |-> o_context_kept == (r.from == mpc_pkg::st_s3))
    else $error("context flag wrong at deep entry");

  a_island_only: assert property (                             // R13
    o_island_only |-> o_supply_on_n && !o_sys_rst_n &&
    r.st == mpc_pkg::st_deep)
    else $error("power kept outside wake island");

  a_deep_return: assert property (                             // R14
    r.st == mpc_pkg::st_deep && wake |=> r.st == $past(r.from) &&
    !o_island_only)
    else $error("wake did not return to entering state");

endmodule : mpc_power_ctrl

// >>> shared/mpc_regs.svh
// timing constants and reset values of the module power control block
// assumes a single 100 MHz reference clock; no software-visible registers
`ifndef MPC_REGS_SVH
`define MPC_REGS_SVH

// reference clock rate in MHz
`define MPC_CLK_MHZ       100
// least time of onboard sequencing after power good, in ns
`define MPC_SEQ_TIME_NS   500
// least dwell in a sleep state before the deepest sleep is entered, in ns
`define MPC_DEEP_TIME_NS  1000
// cycle counts derived from the times above, rounded up
`define MPC_SEQ_CYC  ((`MPC_SEQ_TIME_NS * `MPC_CLK_MHZ + 999) / 1000)
`define MPC_DEEP_CYC ((`MPC_DEEP_TIME_NS * `MPC_CLK_MHZ + 999) / 1000)
// reset value of the synchronised power good level (hold in reset)
`define MPC_PG_RST        1'h0
// reset value of the synchronised button level (released)
`define MPC_BTN_RST       1'h1

`endif

// >>> shared/mpc_pkg.sv
// types of the module power control block
// assumes nothing beyond a SystemVerilog tool; holds no constants
package mpc_pkg;

  // power state of the module
  typedef enum logic [2:0] {
    st_s0,     // running
    st_pwrup,  // supply on, waiting for power good and sequencing
    st_s3,     // suspend to ram
    st_s4,     // suspend to disk
    st_s5,     // soft off
    st_deep    // deepest sleep, only the wake island is powered
  } mpc_state_t;

  // configured response to a power button press
  typedef enum logic [1:0] {
    act_power,   // toggle power on or off
    act_sleep,   // enter suspend to ram from running
    act_ignore,  // no action while running; a press still wakes a sleep state
    act_off      // power off while running; a press in soft off does not power on
  } mpc_action_t;

  // requested sleep type from system software
  typedef enum logic [1:0] {
    slp_s3,
    slp_s4,
    slp_s5,
    slp_none
  } mpc_sleep_t;

  // whole state of the main controller
  typedef struct packed {
    mpc_state_t st;     // present state
    mpc_state_t from;   // sleep state the deepest sleep was entered from
    logic [7:0] cnt;    // dwell and sequencing counter
    logic       rst_n;  // module reset, low = held
    logic       son_n;  // supply on request, low = on
    logic       island; // only the wake island powered
    logic       ctx;    // system context kept in deepest sleep
  } mpc_ctl_t;

endpackage : mpc_pkg

// >>> core/mpc_sync.sv
// two-flop level synchroniser for the carrier inputs
// assumes inputs may change at any time relative to the clock
`timescale 1ns/1ns
`include "mpc_regs.svh"

module mpc_sync (
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  input  wire logic i_power_good_in,
  input  wire logic i_power_button_n,
  output logic      o_power_good,
  output logic      o_button_n
);

  // first stage, read only by the second stage
  logic [1:0] meta;
  logic [1:0] sync;

  ////////////////////////////////////////////////////////////////////////////
  // both stages reset to the safe levels: held in reset, button released
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= {`MPC_PG_RST, `MPC_BTN_RST};
      sync <= {`MPC_PG_RST, `MPC_BTN_RST};
    end else begin
      meta <= {i_power_good_in, i_power_button_n};
      sync <= meta;
    end
  end

  assign o_power_good = sync[1];
  assign o_button_n   = sync[0];

endmodule : mpc_sync

// >>> core/mpc_press.sv
// press detector for the debounced active-low power button
// assumes the button level is already synchronised to the clock
`timescale 1ns/1ns
`include "mpc_regs.svh"

module mpc_press (
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  input  wire logic i_button_n,
  output logic      o_press
);

  logic last_n;  // button level one cycle ago
  logic press;   // registered press pulse

  ////////////////////////////////////////////////////////////////////////////
  // one pulse on each falling edge; a held button gives one pulse only
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last_n <= `MPC_BTN_RST;
      press  <= 1'h0;
    end else begin
      last_n <= i_button_n;
      press  <= last_n & ~i_button_n;
    end
  end

  assign o_press = press;

endmodule : mpc_press

// >>> sim/mpc_carrier.sv
// carrier board model: supply rails, power good line and power button
// assumes both lines have pull-ups at the module pins when released
`timescale 1ns/1ns

module mpc_carrier #(
  parameter int RAIL_CYC = 20  // rail settling cycles, short for the run
) (
  input  wire logic i_ref_clk,
  input  wire logic i_supply_on_n,  // module request, low = rails on
  input  wire logic i_hold_low,     // bench command: force power good low
  input  wire logic i_press,        // bench command: operator presses
  output wire       o_power_good_in,
  output wire       o_power_button_n
);
  ////////////////////////////////////////////////////////////////////////
  int rail_cnt = 0;  // cycles since the rails were switched on

  // rails settle only while the supply is on; switching off restarts
  always @(posedge i_ref_clk) begin
    if (i_supply_on_n) begin
      rail_cnt <= 0;
    end else if (rail_cnt < RAIL_CYC) begin
      rail_cnt <= rail_cnt + 1;
    end
  end

  // drive low until the rails settle or while held low, then float to the pull-up
  assign o_power_good_in = (rail_cnt < RAIL_CYC || i_hold_low)
                           ? 1'h0 : 1'bz;
  // debounced contact to ground, released otherwise
  assign o_power_button_n = i_press ? 1'h0 : 1'bz;
endmodule : mpc_carrier

// >>> sim/tb_top.sv
// self-checking bench of the module power control block
// assumes the carrier model in mpc_carrier.sv; inputs move at negedge
`timescale 1ns/1ns

module tb_top;
  ////////////////////////////////////////////////////////////////////////
  logic       ref_clk = 1'h0;  // 100 MHz reference
  logic       arst_n, hold_low, press, sleep_req, deep_en, wake;
  logic [1:0] action, sleep_type;
  tri1        pg, btn;         // pin pull-ups read released lines high
  wire        sys_rst_n, supply_on_n, island, ctx;
  wire  [2:0] state;
  int         mismatches = 0, n_tests = 0, cycles = 0;

  always #5 ref_clk = ~ref_clk;

  mpc_carrier u_carrier (.i_ref_clk(ref_clk), .i_supply_on_n(supply_on_n),
    .i_hold_low(hold_low), .i_press(press), .o_power_good_in(pg),
    .o_power_button_n(btn));

  mpc_power_ctrl uut (.i_ref_clk(ref_clk), .i_arst_n(arst_n),
    .i_power_good_in(pg), .i_power_button_n(btn), .i_button_action(action),
    .i_sleep_req(sleep_req), .i_sleep_type(sleep_type),
    .i_deep_enable(deep_en), .i_wake_event(wake), .o_sys_rst_n(sys_rst_n),
    .o_supply_on_n(supply_on_n), .o_power_state(state),
    .o_island_only(island), .o_context_kept(ctx));

  ////////////////////////////////////////////////////////////////////////
  // compare one value, count it and report a mismatch
  task chk(input logic [2:0] got, input logic [2:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk

  // wait a bounded number of cycles for a state, then compare
  task wait_st(input logic [2:0] exp, input int lim, input string m);
    int n;
    n = 0;
    while (state !== exp && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    chk(state, exp, m);
  endtask : wait_st

  // hold the button for six cycles with the given response selected
  task push(input logic [1:0] act);
    @(negedge ref_clk);
    action = act;
    press = 1'h1;
    repeat (6) @(negedge ref_clk);
    press = 1'h0;
  endtask : push

  // one-cycle wake event
  task wake_pulse;
    wake = 1'h1;
    @(negedge ref_clk);
    wake = 1'h0;
  endtask : wake_pulse

  ////////////////////////////////////////////////////////////////////////
  // block sits off with reset held once reset is released
  task t_reset;
    repeat (4) @(negedge ref_clk);
    chk(state, 3'h4, "not off after reset");
    chk({2'h0, sys_rst_n}, 3'h0, "reset free after reset");
    chk({2'h0, supply_on_n}, 3'h1, "supply on after reset");
    $display("test reset done");
  endtask : t_reset

  // power on by button, reset held until power good has settled
  task t_power_on;
    push(2'h0);
    chk(state, 3'h1, "not powering up");
    chk({2'h0, supply_on_n}, 3'h0, "supply not on");
    repeat (15) @(negedge ref_clk);
    chk({2'h0, sys_rst_n}, 3'h0, "reset free while pg low");
    wait_st(3'h0, 200, "not running after pg");
    chk({2'h0, sys_rst_n}, 3'h1, "reset not released");
    $display("test power on done");
  endtask : t_power_on

  // power good lost while running, then floated high again
  task t_pg_loss;
    hold_low = 1'h1;
    repeat (4) @(negedge ref_clk);
    chk(state, 3'h1, "pg loss ignored");
    chk({2'h0, sys_rst_n}, 3'h0, "reset not held");
    hold_low = 1'h0;
    wait_st(3'h0, 100, "no restart after pg");
    $display("test pg loss done");
  endtask : t_pg_loss

  // every configured button response
  task t_buttons;
    push(2'h2);
    repeat (4) @(negedge ref_clk);
    chk(state, 3'h0, "ignore acted");
    push(2'h1);
    chk(state, 3'h2, "no sleep by button");
    push(2'h0);
    chk(state, 3'h1, "no wake by button");
    wait_st(3'h0, 200, "not running again");
    push(2'h0);
    chk(state, 3'h4, "no power off");
    chk({2'h0, supply_on_n}, 3'h1, "supply still on");
    push(2'h3);
    repeat (4) @(negedge ref_clk);
    chk(state, 3'h4, "off-only powered on");
    t_power_on();
    $display("test buttons done");
  endtask : t_buttons

  // each sleep type but none (S3, S4, S5), deepest sleep, resume and wake
  task t_deep;
    logic [2:0] e;
    for (int t = 0; t < 3; t++) begin
      e = 3'h2 + t[2:0];
      deep_en = 1'h1;
      sleep_type = t[1:0];
      repeat (120) @(negedge ref_clk);
      chk(state, 3'h0, "deep from running");
      sleep_req = 1'h1;
      @(negedge ref_clk);
      sleep_req = 1'h0;
      chk(state, e, "sleep not entered");
      wait_st(3'h5, 150, "deep not entered");
      chk({2'h0, island}, 3'h1, "island not alone");
      chk({2'h0, ctx}, {2'h0, t == 0}, "context flag");
      deep_en = 1'h0;
      wake_pulse();
      chk(state, e, "wrong resume state");
      chk({2'h0, island}, 3'h0, "island after resume");
      @(negedge ref_clk);
      wake_pulse();
      chk(state, 3'h1, "no power up on wake");
      wait_st(3'h0, 200, "not running after wake");
    end
    $display("test deep done");
  endtask : t_deep

  // sleep type none and the off-only response while running
  task t_codes;
    sleep_type = 2'h3;
    sleep_req = 1'h1;
    @(negedge ref_clk);
    sleep_req = 1'h0;
    repeat (2) @(negedge ref_clk);
    chk(state, 3'h0, "sleep type none acted");
    push(2'h3);
    chk(state, 3'h4, "off-only kept power");
    chk({2'h0, supply_on_n}, 3'h1, "supply on after off");
    $display("test codes done");
  endtask : t_codes

  ////////////////////////////////////////////////////////////////////////
  // print the counts and the verdict, then stop
  task finish_test;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  // cut a hang short well beyond the expected run length
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      mismatches++;
      $display("[ERR] %0t run timed out", $time);
      finish_test();
    end
  end

  // main sequence
  initial begin
    {arst_n, hold_low, press, sleep_req, deep_en, wake} = 6'h00;
    action = 2'h0;
    sleep_type = 2'h3;
    repeat (16) @(negedge ref_clk);
    arst_n = 1'h1;
    t_reset();
    t_power_on();
    t_pg_loss();
    t_buttons();
    t_deep();
    t_codes();
    finish_test();
  end
endmodule : tb_top
